// ### rtl/spio_pkg.sv
// Package with register map, field positions and reset values for the shared-pin ports C, D, E.
package spio_pkg;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] PORT_C_DATA_OFS = 4'h2;
    localparam logic [ADDR_W-1:0] PORT_D_DATA_OFS = 4'h3;
    localparam logic [ADDR_W-1:0] PORT_C_DIR_OFS  = 4'h6;
    localparam logic [ADDR_W-1:0] PORT_D_DIR_OFS  = 4'h7;
    localparam logic [ADDR_W-1:0] PORT_E_DATA_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] PORT_E_DIR_OFS  = 4'hc;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int PORT_C_W          = 6;
    localparam int SYSCLK_OUT_EN_BIT = 7;
    localparam int PORT_C_CLK_PIN    = 2;
    localparam int ADC_PIN_CNT       = 7;
    localparam int TA_CLK_PIN        = 6;
    localparam int TB_CLK_PIN        = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DIR_RST  = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

endpackage : spio_pkg

// ### rtl/spio_sync.sv
// Two-flip-flop synchroniser for a bank of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module spio_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic         clk_en_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] stage1_reg;

    // ------------------------------------------------------------------
    // Sync chain
    // ------------------------------------------------------------------
    // The first stage feeds only the second, so metastability never reaches logic.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            stage1_reg <= '0;
            sync_o     <= '0;
        end else if (clk_en_i) begin
            stage1_reg <= async_i;
            sync_o     <= stage1_reg;
        end
    end
endmodule : spio_sync
`default_nettype wire

// ### rtl/spio_ports.sv
// Pin multiplexing, data latches and direction registers for ports C, D and E.
// Ports C, D and E lend their pins to the system clock output, converter
// inputs, timer pins and both serial interfaces. Ownership takes the drive
// away from the direction bits; reads follow them, except owned port D input bits and the enabled clock pin read zero.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module spio_ports
    import spio_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              clk_en_i,
    // Register port.
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    // Pins.
    input  wire logic [5:0]        port_c_pin_i,
    output logic      [5:0]        port_c_pin_o,
    output logic      [5:0]        port_c_pin_oe_n_o,
    input  wire logic [7:0]        port_d_pin_i,
    output logic      [7:0]        port_d_pin_o,
    output logic      [7:0]        port_d_pin_oe_n_o,
    input  wire logic [7:0]        port_e_pin_i,
    output logic      [7:0]        port_e_pin_o,
    output logic      [7:0]        port_e_pin_oe_n_o,
    // Peripheral selects.
    input  wire logic [6:0]        adc_channel_pin_i,
    input  wire logic              timer_a_ext_clock_sel_i,
    input  wire logic              timer_b_ext_clock_sel_i,
    input  wire logic [1:0]        timer_a_channel_pin_en_i,
    input  wire logic [1:0]        timer_a_channel_out_i,
    input  wire logic [1:0]        timer_a_channel_oe_i,
    input  wire logic              serial_periph_enable_i,
    input  wire logic              serial_periph_master_sel_i,
    input  wire logic              spi_sck_out_i,
    input  wire logic              spi_mosi_out_i,
    input  wire logic              spi_miso_out_i,
    input  wire logic              spi_miso_oe_i,
    input  wire logic              async_serial_enable_i,
    input  wire logic              async_serial_txd_i,
    // Synchronised pin levels towards the peripherals.
    output logic      [7:0]        port_d_level_o,
    output logic      [7:0]        port_e_level_o
);

    // ------------------------------------------------------------------
    // Registers and synchronised pins
    // ------------------------------------------------------------------
    // All state below freezes while the clock enable is low.
    // Port C has six pins, so its latch and directions are six bits wide.
    logic [5:0] port_c_data_latch_reg;
    logic [5:0] port_c_direction_reg;
    logic       sysclk_out_enable_reg;
    logic [7:0] port_d_data_latch_reg;
    logic [7:0] port_d_direction_reg;
    logic [7:0] port_e_data_latch_reg;
    logic [7:0] port_e_direction_reg;
    // Pin images after the two-flop synchronisers.
    logic [5:0] c_sync;
    logic [7:0] d_sync;
    logic [7:0] e_sync;
    // Combinational helpers for the read mux and the pin drivers.
    logic [7:0] rdata_next;
    logic [7:0] d_own;
    logic [7:0] e_own;
    logic [7:0] e_drv;
    logic [7:0] e_val;
    // Divider state for the clock output on port C pin 2.
    logic       clk_div_reg;

    // Every pin passes two flip-flops before the read mux sees it; port D and E pins pass three before a peripheral does.
    // The price is two cycles of latency on every pin read.
    spio_sync #(.W(6)) u_sync_c (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .clk_en_i  (clk_en_i),
        .async_i   (port_c_pin_i),
        .sync_o    (c_sync)
    );
    spio_sync #(.W(8)) u_sync_d (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .clk_en_i  (clk_en_i),
        .async_i   (port_d_pin_i),
        .sync_o    (d_sync)
    );
    spio_sync #(.W(8)) u_sync_e (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .clk_en_i  (clk_en_i),
        .async_i   (port_e_pin_i),
        .sync_o    (e_sync)
    );

    // ------------------------------------------------------------------
    // Data latches
    // ------------------------------------------------------------------
    // Latches keep the written value whatever the direction, so software can
    // preload a level before it turns a pin into an output.
    // latch always written
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            port_c_data_latch_reg <= DATA_RST[5:0];
            port_d_data_latch_reg <= DATA_RST;
            port_e_data_latch_reg <= DATA_RST;
        end else if (clk_en_i && wr_i) begin
            if (addr_i == PORT_C_DATA_OFS) port_c_data_latch_reg <= wdata_i[5:0];
            if (addr_i == PORT_D_DATA_OFS) port_d_data_latch_reg <= wdata_i;
            if (addr_i == PORT_E_DATA_OFS) port_e_data_latch_reg <= wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // Direction registers
    // ------------------------------------------------------------------
    // The clock-out enable shares its address with the port C directions.
    // Bit 6 of that address has no storage and reads zero.
    // reset clears directions
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            port_c_direction_reg  <= DIR_RST[5:0];
            sysclk_out_enable_reg <= 1'b0;
            port_d_direction_reg  <= DIR_RST;
            port_e_direction_reg  <= DIR_RST;
        end else if (clk_en_i && wr_i) begin
            if (addr_i == PORT_C_DIR_OFS) begin
                port_c_direction_reg  <= wdata_i[5:0];
                sysclk_out_enable_reg <= wdata_i[SYSCLK_OUT_EN_BIT];
            end
            if (addr_i == PORT_D_DIR_OFS) port_d_direction_reg <= wdata_i;
            if (addr_i == PORT_E_DIR_OFS) port_e_direction_reg <= wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Port D pins owned by the ADC or a timer clock; direction bits stop steering their drive.
    // The converter select is a level from the converter, held as long as it owns the pin.
    assign d_own = {1'b0, adc_channel_pin_i}
                 | ({7'h00, timer_a_ext_clock_sel_i} << TA_CLK_PIN)
                 | ({7'h00, timer_b_ext_clock_sel_i} << TB_CLK_PIN);

    // Port E ownership per pin.
    // Slave select belongs to the serial peripheral only in slave mode; the
    // timer channels follow their own pin enables.
    // slave select owned only in slave mode
    assign e_own = {{3{serial_periph_enable_i}},
                    serial_periph_enable_i & ~serial_periph_master_sel_i,
                    timer_a_channel_pin_en_i,
                    {2{async_serial_enable_i}}};

    // Owned port E pins still read through their direction bits; owned port D pins read the
    // latch where output and zero where input. Unmapped addresses read zero so holes never leak state.
    // latch or pin by direction
    always_comb begin
        rdata_next = 8'h00;
        case (addr_i)
            PORT_C_DATA_OFS: begin
                for (int i = 0; i < PORT_C_W; i++) begin
                    rdata_next[i] = port_c_direction_reg[i] ? port_c_data_latch_reg[i] : c_sync[i];
                end
                if (sysclk_out_enable_reg) rdata_next[PORT_C_CLK_PIN] = 1'b0;
            end
            PORT_D_DATA_OFS: begin
                for (int i = 0; i < 8; i++) begin
                    if (d_own[i])
                        rdata_next[i] = port_d_direction_reg[i] & port_d_data_latch_reg[i];
                    else
                        rdata_next[i] = port_d_direction_reg[i] ? port_d_data_latch_reg[i]
                                                                : d_sync[i];
                end
            end
            PORT_E_DATA_OFS: begin
                for (int i = 0; i < 8; i++) begin
                    rdata_next[i] = port_e_direction_reg[i] ? port_e_data_latch_reg[i] : e_sync[i];
                end
            end
            PORT_C_DIR_OFS: rdata_next = {sysclk_out_enable_reg, 1'b0, port_c_direction_reg};
            PORT_D_DIR_OFS: rdata_next = port_d_direction_reg;
            PORT_E_DIR_OFS: rdata_next = port_e_direction_reg;
            default:        rdata_next = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    // Returning zero outside a read keeps a shared read bus quiet.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            rdata_o <= rd_i ? rdata_next : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Clock output
    // ------------------------------------------------------------------
    // clock onto pin
    // A registered output cannot carry the clock itself, so the pin toggles each
    // edge, giving half the system rate; a true clock mux would break the flop-output rule.
    // Limitation: the pin starts toggling two cycles after the enable is written,
    // and software reads zero on that pin bit while the clock output is enabled.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            clk_div_reg <= 1'b0;
        end else if (clk_en_i) begin
            clk_div_reg <= sysclk_out_enable_reg ? ~clk_div_reg : 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Port E drive values
    // ------------------------------------------------------------------
    // SPI clock out as master
    // serial pins
    // Peripheral output enables per pin; a one lets the owner drive its pin.
    assign e_drv = {serial_periph_master_sel_i,                  // Clock out as master.
                    serial_periph_master_sel_i,                  // Data out as master.
                    spi_miso_oe_i & ~serial_periph_master_sel_i, // Data out as slave.
                    1'b0,                                        // Slave select is input only.
                    timer_a_channel_oe_i,                        // Timer channels.
                    1'b0,                                        // Serial receive is input only.
                    1'b1};                                       // Serial transmit drives.
    // Values the owners put on the pins they drive.
    assign e_val = {spi_sck_out_i,
                    spi_mosi_out_i,
                    spi_miso_out_i,
                    1'b0,
                    timer_a_channel_out_i,
                    1'b0,
                    async_serial_txd_i};

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // direction enables buffer
    // timer clock pin ignores direction
    // Every pin output and enable is registered, so the pins change one cycle
    // after the register write that caused it.
    // Owned port D pins are always released; the converter and timer clock
    // inputs need them undriven.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            port_c_pin_o      <= 6'h00;
            port_c_pin_oe_n_o <= 6'h3f;
            port_d_pin_o      <= 8'h00;
            port_d_pin_oe_n_o <= 8'hff;
            port_e_pin_o      <= 8'h00;
            port_e_pin_oe_n_o <= 8'hff;
            port_d_level_o    <= 8'h00;
            port_e_level_o    <= 8'h00;
        end else if (clk_en_i) begin
            port_c_pin_o      <= port_c_data_latch_reg;
            port_c_pin_oe_n_o <= ~port_c_direction_reg;
            if (sysclk_out_enable_reg) begin
                port_c_pin_o[PORT_C_CLK_PIN]      <= clk_div_reg;
                port_c_pin_oe_n_o[PORT_C_CLK_PIN] <= 1'b0;
            end
            port_d_pin_o      <= port_d_data_latch_reg;
            port_d_pin_oe_n_o <= ~(port_d_direction_reg & ~d_own);
            // Port E: the owner decides drive and value pin by pin.
            for (int i = 0; i < 8; i++) begin
                port_e_pin_o[i]      <= e_own[i] ? e_val[i] : port_e_data_latch_reg[i];
                port_e_pin_oe_n_o[i] <= e_own[i] ? ~e_drv[i] : ~port_e_direction_reg[i];
            end
            port_d_level_o <= d_sync;
            port_e_level_o <= e_sync;
        end
    end

endmodule : spio_ports
`default_nettype wire

// ### dv/spio_ports_properties.sv
// Concurrent checks on the register port and pin sharing of spio_ports.
`timescale 1ns/1ps
`default_nettype none
module spio_ports_properties
    import spio_pkg::*;
(
    input wire logic              sys_clk_i, rst_i, clk_en_i, wr_i, rd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0]        wdata_i, rdata_o, port_d_pin_oe_n_o,
    input wire logic [7:0]        port_e_pin_o, port_e_pin_oe_n_o,
    input wire logic [5:0]        port_c_pin_o, port_c_pin_oe_n_o,
    input wire logic [6:0]        adc_channel_pin_i,
    input wire logic              timer_a_ext_clock_sel_i, timer_b_ext_clock_sel_i,
    input wire logic              serial_periph_enable_i, serial_periph_master_sel_i,
    input wire logic              spi_sck_out_i, async_serial_enable_i, async_serial_txd_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Shadow of the clock-out enable, so pin 2 is judged without looking inside.
    logic cko_reg;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            cko_reg <= 1'b0;
        else if (wr_i && clk_en_i && addr_i == PORT_C_DIR_OFS)
            cko_reg <= wdata_i[SYSCLK_OUT_EN_BIT];
    end

    rd_quiet_a: assert property (
        !rd_i && clk_en_i |=> rdata_o == 8'h00) else $error("read data outside a read");
    rst_inputs_a: assert property (
        $fell(rst_i) |-> &port_c_pin_oe_n_o && &port_d_pin_oe_n_o) else $error("pin driven at reset");
    clk_out_a: assert property (
        cko_reg && $past(cko_reg) && $past(cko_reg, 2) |-> !port_c_pin_oe_n_o[2]
        && port_c_pin_o[2] != $past(port_c_pin_o[2])) else $error("clock out not toggling");
    c_read_a: assert property (
        rd_i && clk_en_i && addr_i == PORT_C_DATA_OFS |=> rdata_o[7:6] == 2'b00
        && !($past(cko_reg) && rdata_o[2])) else $error("port C read bits not zero");
    adc_inert_a: assert property (
        $stable(adc_channel_pin_i) |-> &(port_d_pin_oe_n_o[6:0] | ~adc_channel_pin_i))
        else $error("converter pin driven");
    tclk_inert_a: assert property (
        $stable({timer_a_ext_clock_sel_i, timer_b_ext_clock_sel_i})
        |-> (!timer_a_ext_clock_sel_i || port_d_pin_oe_n_o[TA_CLK_PIN])
        && (!timer_b_ext_clock_sel_i || port_d_pin_oe_n_o[TB_CLK_PIN])) else $error("timer clock pin driven");
    spi_slave_a: assert property (
        $stable({serial_periph_enable_i, serial_periph_master_sel_i}) && serial_periph_enable_i
        && !serial_periph_master_sel_i |-> port_e_pin_oe_n_o[7] && port_e_pin_oe_n_o[4])
        else $error("slave input pin driven");
    spi_master_a: assert property (
        !$past(rst_i) && $stable({serial_periph_enable_i, serial_periph_master_sel_i})
        && serial_periph_enable_i && serial_periph_master_sel_i |-> port_e_pin_oe_n_o[7:6] == 2'b00
        && port_e_pin_o[7] == $past(spi_sck_out_i)) else $error("master pins wrong");
    sci_pins_a: assert property (
        !$past(rst_i) && $stable(async_serial_enable_i) && async_serial_enable_i
        |-> port_e_pin_oe_n_o[1:0] == 2'b10 && port_e_pin_o[0] == $past(async_serial_txd_i))
        else $error("serial pins wrong");
endmodule : spio_ports_properties

bind spio_ports spio_ports_properties u_props (
    .sys_clk_i, .rst_i, .clk_en_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
    .port_d_pin_oe_n_o, .port_e_pin_o, .port_e_pin_oe_n_o, .port_c_pin_o,
    .port_c_pin_oe_n_o, .adc_channel_pin_i, .timer_a_ext_clock_sel_i,
    .timer_b_ext_clock_sel_i, .serial_periph_enable_i, .serial_periph_master_sel_i,
    .spi_sck_out_i, .async_serial_enable_i, .async_serial_txd_i
);
`default_nettype wire

// ### dv/spio_pin_model.sv
// Board wiring of one port: the output buffer or the external driver sets each pin.
`timescale 1ns/1ps
`default_nettype none
module spio_pin_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] drive_i,
    input  wire logic [W-1:0] oe_n_i,
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] level_o
);
    // enabled buffer wins
    // The external side only drives pins that the block has released.
    always_comb level_o = (~oe_n_i & drive_i) | (oe_n_i & ext_i);
endmodule : spio_pin_model
`default_nettype wire

// ### dv/spio_ports_tb.sv
// Self-checking bench for the shared-pin ports C, D and E.
`timescale 1ns/1ps
`default_nettype none
module spio_ports_tb;
    import spio_pkg::*;
    logic              sys_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [7:0]        wdata_i = '0, rdata_o, ext_c = '0, ext_d = '0, ext_e = '0, ser = '0;
    logic [7:0]        pdo, pd_oe_n, pd_i, peo, pe_oe_n, pe_i, d, lc, ld, le, dc, dd, de;
    logic [7:0]        own_d, own_e, pdm, pdv, drv_e, lvd, lve;
    logic [5:0]        pco, pc_oe_n, pc_i;
    logic [14:0]       tmr = '0;
    logic [63:0]       q;
    logic [31:0]       r;
    logic              b;
    int                failures = 0, n_tests = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    spio_ports DUT (
        .sys_clk_i, .rst_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .port_c_pin_i(pc_i), .port_c_pin_o(pco), .port_c_pin_oe_n_o(pc_oe_n),
        .port_d_pin_i(pd_i), .port_d_pin_o(pdo), .port_d_pin_oe_n_o(pd_oe_n),
        .port_e_pin_i(pe_i), .port_e_pin_o(peo), .port_e_pin_oe_n_o(pe_oe_n),
        .adc_channel_pin_i(tmr[14:8]), .timer_a_ext_clock_sel_i(tmr[7]),
        .timer_b_ext_clock_sel_i(tmr[6]), .timer_a_channel_pin_en_i(tmr[5:4]),
        .timer_a_channel_out_i(tmr[3:2]), .timer_a_channel_oe_i(tmr[1:0]),
        .serial_periph_enable_i(ser[7]), .serial_periph_master_sel_i(ser[6]),
        .spi_sck_out_i(ser[5]), .spi_mosi_out_i(ser[4]), .spi_miso_out_i(ser[3]),
        .spi_miso_oe_i(ser[2]), .async_serial_enable_i(ser[1]), .async_serial_txd_i(ser[0]),
        .port_d_level_o(lvd), .port_e_level_o(lve)
    );
    spio_pin_model #(.W(6)) u_pc (.drive_i(pco), .oe_n_i(pc_oe_n), .ext_i(ext_c[5:0]), .level_o(pc_i));
    spio_pin_model #(.W(8)) u_pd (.drive_i(pdo), .oe_n_i(pd_oe_n), .ext_i(ext_d), .level_o(pd_i));
    spio_pin_model #(.W(8)) u_pe (.drive_i(peo), .oe_n_i(pe_oe_n), .ext_i(ext_e), .level_o(pe_i));

    // ------------------------------------------------------------------
    // Bus cycles, comparison and closing
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd

    // Expected read: latch where output, pin where input, zero on input bits set in zm.
    task automatic check_port(input logic [ADDR_W-1:0] a, input logic [7:0] dir, lat, zm, drv,
                              input logic [7:0] val, ext, po, oen);
        logic [7:0] pin;
        pin = (drv & val) | (~drv & ext);
        rd(a, d);
        chk(d, (dir & lat) | (~dir & ~zm & pin));
        chk(oen, ~drv);
        chk(po & drv, val & drv);
    endtask : check_port

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        #100000;
        failures++;
        end_of_test();
    end

    initial begin
        void'($urandom(60610));
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Writes to holes must be dropped; holes and directions then read zero.
        for (int a = 0; a < 16; a++)
            if (!(a inside {2, 3, 6, 7, 8, 12})) wr(a[3:0], 8'hff);
        for (int a = 0; a < 16; a++)
            if (!(a inside {2, 3, 8})) begin
                rd(a[3:0], d);
                chk(d, 8'h00);
            end
        $display("test register map done");
        // Random pins, latches, directions and peripheral ownership.
        repeat (40) begin
            @(posedge sys_clk_i);
            q = {$urandom, $urandom};
            r = $urandom;
            tmr   <= r[14:0];
            ser   <= r[22:15];
            ext_c <= q[55:48];
            ext_d <= q[63:56];
            ext_e <= r[31:24];
            {le, ld, lc} = q[23:0];
            {de, dd, dc} = q[47:24] & 24'hffff3f;
            wr(PORT_C_DATA_OFS, lc);
            wr(PORT_D_DATA_OFS, ld);
            wr(PORT_E_DATA_OFS, le);
            wr(PORT_C_DIR_OFS, dc);
            wr(PORT_D_DIR_OFS, dd);
            wr(PORT_E_DIR_OFS, de);
            repeat (4) @(posedge sys_clk_i);
            #1;
            own_d = {1'b0, tmr[14:8] | {tmr[7], 1'b0, tmr[6], 4'h0}};
            own_e = {{3{ser[7]}}, ser[7] & ~ser[6], tmr[5:4], {2{ser[1]}}};
            pdm   = {{2{ser[7] & ser[6]}}, ser[7] & ~ser[6] & ser[2], 1'b0, tmr[5:4] & tmr[1:0],
                     1'b0, ser[1]};
            pdv   = {ser[5:3], 1'b0, tmr[3:2], 1'b0, ser[0]};
            drv_e = (own_e & pdm) | (~own_e & de);
            chk(lvd, ((dd & ~own_d) & ld) | (~(dd & ~own_d) & ext_d));
            chk(lve, (drv_e & ((own_e & pdv) | (~own_e & le))) | (~drv_e & ext_e));
            check_port(PORT_C_DATA_OFS, dc, lc, 8'hc0, dc, lc, ext_c, {2'b00, pco}, {2'b11, pc_oe_n});
            check_port(PORT_D_DATA_OFS, dd, ld, own_d, dd & ~own_d, ld, ext_d, pdo, pd_oe_n);
            check_port(PORT_E_DATA_OFS, de, le, 8'h00, drv_e, (own_e & pdv) | (~own_e & le),
                       ext_e, peo, pe_oe_n);
        end
        $display("test pin sharing done");
        // Clock enable low: a write must not land and the pins must hold.
        @(posedge sys_clk_i);
        clk_en_i <= 1'b0;
        wr(PORT_D_DIR_OFS, ~dd);
        clk_en_i <= 1'b1;
        rd(PORT_D_DIR_OFS, d);
        chk(d, dd);
        chk(pd_oe_n, ~(dd & ~own_d));
        $display("test clock enable done");
        // Clock out on port C pin 2 with its direction bit also set.
        wr(PORT_C_DIR_OFS, 8'h84);
        repeat (3) @(posedge sys_clk_i);
        #1 b = pco[2];
        @(posedge sys_clk_i);
        #1 chk({7'h00, pco[2]}, {7'h00, ~b});
        chk({7'h00, pc_oe_n[2]}, 8'h00);
        rd(PORT_C_DIR_OFS, d);
        chk(d, 8'h84);
        rd(PORT_C_DATA_OFS, d);
        chk(d & 8'h04, 8'h00);
        $display("test clock out done");
        end_of_test();
    end
endmodule : spio_ports_tb
`default_nettype wire
